// [inc/sp_pkg.sv]
/*
 Shared constants of the sector protection core: opcodes, frame lengths,
 protection mode codes, status bit positions and timing counts.
 Assumes a 25 MHz core clock; the serial clock is a separate domain.
*/
package sp_pkg;
    localparam int MCLK_HZ = 25_000_000;
    localparam int MCLK_MHZ = MCLK_HZ / 1_000_000;
    // Unlock retry gap, exact at this clock rate
    localparam int GAP_US = 100;
    localparam int GAP_CYC = GAP_US * MCLK_MHZ;
    // Embedded operation time, least time rounded up
    localparam int OP_NS = 2000;
    localparam int OP_CYC = (OP_NS * MCLK_MHZ + 999) / 1000;
    localparam int WIP_W = 12;
    localparam logic [WIP_W-1:0] GAP_LD = WIP_W'(GAP_CYC);
    localparam logic [WIP_W-1:0] OP_LD = WIP_W'(OP_CYC);
    localparam logic [WIP_W-1:0] WIP_ONE = 12'h001;
    localparam logic [WIP_W-1:0] WIP_ZERO = 12'h000;

    localparam int SECT_N = 256;
    localparam int SECT_W = 8;
    localparam int SECT_LSB = 19;
    localparam int VSECT_LSB = SECT_LSB + 8;
    localparam int PWD_W = 64;
    localparam int ACC_W = 64;

    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_CLSR = 8'h30;
    localparam logic [7:0] OP_SRST = 8'hF0;
    localparam logic [7:0] OP_RD3 = 8'h03;
    localparam logic [7:0] OP_RD4 = 8'h13;
    localparam logic [7:0] OP_FREAD = 8'h0B;
    localparam logic [7:0] OP_PP3 = 8'h02;
    localparam logic [7:0] OP_PP4 = 8'h12;
    localparam logic [7:0] OP_LCLR = 8'hA6;
    localparam logic [7:0] OP_UNLK = 8'hE9;
    localparam logic [7:0] OP_PWDP = 8'hE8;
    localparam logic [7:0] OP_PWDR = 8'hE7;
    localparam logic [7:0] OP_PPGM = 8'hE3;
    localparam logic [7:0] OP_PERA = 8'hE4;
    localparam logic [7:0] OP_PRD = 8'hE2;
    localparam logic [7:0] OP_VWR = 8'hE1;
    localparam logic [7:0] OP_VRD = 8'hE0;
    localparam logic [7:0] OP_MODEP = 8'h2F;

    // Byte counts of a frame, opcode included
    localparam logic [3:0] LEN_NONE = 4'h0;
    localparam logic [3:0] LEN_OP = 4'h1;
    localparam logic [3:0] LEN_MODE = 4'h2;
    localparam logic [3:0] LEN_A3 = 4'h4;
    localparam logic [3:0] LEN_A4 = 4'h5;
    localparam logic [3:0] LEN_VWR = 4'h6;
    localparam logic [3:0] LEN_PWD = 4'h9;
    localparam logic [3:0] LEN_MAX = 4'hF;

    localparam logic [1:0] MODE_NONE = 2'h3;
    localparam logic [1:0] MODE_PERS = 2'h2;
    localparam logic [1:0] MODE_PWD = 2'h1;
    localparam logic [1:0] MODE_BAD = 2'h0;
    localparam int MODE_LSB = 1;
    localparam logic [3:0] CONT_NIB = 4'hA;

    localparam int STAT_WIP = 0;
    localparam int STAT_PERR = 6;
    localparam int STAT_LOCK = 7;
    localparam logic [2:0] BIT_LAST = 3'h7;
endpackage : sp_pkg

// [inc/spi_link_if.sv]
/*
 Carrier between the serial-clock side and the core-clock side.
 Assumes rx and mid are read only after the toggle or frame end is
 synchronised, and tx is held steady for at least a byte time.
*/
interface spi_link_if;
    logic tgl;
    logic mid;
    logic [7:0] rx;
    logic [7:0] tx;
    modport link (output tgl, output mid, output rx, input tx);
    modport core (input tgl, input mid, input rx, output tx);
endinterface : spi_link_if

// [logic/spi_link.sv]
/*
 Serial shifter on the host's clock: bytes in on the serial input,
 answer bytes out on falling edges, one toggle per received byte.
 Assumes mode 0 clocking and a clock that runs only inside frames.
*/
module spi_link (
    input wire logic i_sck,
    input wire logic i_nrst,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    spi_link_if.link lk
);
    import sp_pkg::*;

    logic first_r;
    logic [2:0] bit_r;
    logic [6:0] sh_r;
    logic [7:0] rx_r;
    logic [7:0] hold_r;
    logic tgl_r;
    logic so_r;
    wire [2:0] pos = first_r ? 3'h0 : bit_r;
    wire last = (pos == BIT_LAST);

    // Frame start restarts the bit count
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    // Bit count survives the frame end so the core can judge alignment
    always_ff @(posedge i_sck or negedge i_nrst) begin
        if (!i_nrst) begin
            bit_r <= 3'h0;
            tgl_r <= 1'b0;
            rx_r <= 8'h00;
            hold_r <= 8'h00;
            sh_r <= 7'h00;
        end else begin
            bit_r <= pos + 3'h1;
            sh_r <= {sh_r[5:0], i_si};
            if (last) begin
                rx_r <= {sh_r, i_si};
                tgl_r <= ~tgl_r;
                hold_r <= lk.tx;
            end
        end
    end

    always_ff @(negedge i_sck or negedge i_nrst) begin
        if (!i_nrst) begin
            so_r <= 1'b0;
        end else begin
            so_r <= hold_r[~bit_r];
        end
    end

    assign lk.rx = rx_r;
    assign lk.tgl = tgl_r;
    assign lk.mid = (bit_r != 3'h0);
    assign o_so = so_r;
    assign o_so_oe = ~i_cs_n;
endmodule : spi_link

// [logic/sector_protect.sv]
/*
 Sector protection core: lock bit, persistent and volatile sector bits,
 password unlock with retry gap, and serial command framing.
 Assumes nonvolatile cells outside load i_nv_* while reset is low and
 store o_nv_*; array data answers o_rd_addr within a byte time.
*/
// Contract
// - One volatile lock gates all persistent bits
// - Lock clear command drives lock to zero
// - Persistent mode: reset sets lock, commands cannot
// - Password mode: reset clears lock, unlock sets
// - Sector writable only when both bits one
// - Persistent bits change only while lock set
// - Volatile bits unprotect on resets, persistent kept
// - Full password compare before lock is set
// - Mismatch: lock kept, error set, busy held
// - Unlock retry gap; match ends busy at once
// - Password program only clears bits
// - Password mode ignores password read and program
// - Password has own space, two commands only
// - Every command starts with eight-bit opcode
// - Address phase is three or four bytes
// - MSB first, data at incrementing addresses
// - Mode byte allows opcode-free continuation frames
// - Dummy cycles precede read data
// - Busy device ignores array reads, most commands
// - Chip select frames command; misaligned end rejected
// - Address arrives on the serial input only
// - Locked persistent program or erase fails
// - Mode bits 11,10,01 valid; 00 fails
// - Volatile write zero protects, one unprotects
module sector_protect (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    input wire logic [sp_pkg::SECT_N-1:0] i_nv_pers,
    input wire logic [sp_pkg::PWD_W-1:0] i_nv_pwd,
    input wire logic [1:0] i_nv_mode,
    output logic [sp_pkg::SECT_N-1:0] o_nv_pers,
    output logic [sp_pkg::PWD_W-1:0] o_nv_pwd,
    output logic [1:0] o_nv_mode,
    output logic [sp_pkg::SECT_N-1:0] o_sector_unprot,
    output logic o_lock,
    output logic o_wip,
    output logic o_p_err,
    output logic [31:0] o_rd_addr,
    input wire logic [7:0] i_rd_data,
    output logic o_wr_req,
    output logic [31:0] o_wr_addr
);
    import sp_pkg::*;

    typedef enum logic [1:0] {
        ST_CMD = 2'h0,
        ST_HDR = 2'h1,
        ST_RD = 2'h2,
        ST_IGN = 2'h3
    } st_t;

    spi_link_if lk ();

    spi_link u_link (
        .i_sck(i_sck),
        .i_nrst(i_nrst),
        .i_cs_n(i_cs_n),
        .i_si(i_si),
        .o_so(o_so),
        .o_so_oe(o_so_oe),
        .lk(lk.link)
    );

    logic cs_s1, cs_s2, cs_s3, cs_s4;
    logic tg_s1, tg_s2, tg_s3;
    logic mid_s1, mid_s2;
    st_t st_r, st_nxt;
    logic [7:0] cmd_r;
    logic [3:0] cnt_r;
    logic [ACC_W-1:0] acc_r;
    logic [31:0] rd_ptr_r;
    logic cont_r;
    logic lock_r;
    logic p_err_r;
    logic [WIP_W-1:0] wip_cnt_r;
    logic [SECT_N-1:0] pers_r, vol_r, pers_nxt, vol_nxt, unprot_r;
    logic [PWD_W-1:0] pwd_r;
    logic [1:0] mode_r;
    logic wr_req_r;
    logic [31:0] wr_addr_r;
    logic [7:0] stat_w;

    // Both crossings settle two cycles; frame end waits one more
    // so a last byte event is always handled first
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            {cs_s1, cs_s2, cs_s3, cs_s4} <= 4'hF;
            {tg_s1, tg_s2, tg_s3} <= 3'h0;
            {mid_s1, mid_s2} <= 2'h0;
        end else begin
            {cs_s1, cs_s2, cs_s3, cs_s4} <= {i_cs_n, cs_s1, cs_s2, cs_s3};
            {tg_s1, tg_s2, tg_s3} <= {lk.tgl, tg_s1, tg_s2};
            {mid_s1, mid_s2} <= {lk.mid, mid_s1};
        end
    end

    wire byte_ev = tg_s2 ^ tg_s3;
    wire frame_end = cs_s3 & ~cs_s4;
    wire [7:0] rx = lk.rx;
    wire busy = (wip_cnt_r != WIP_ZERO);
    wire pwd_mode = (mode_r == MODE_PWD);
    wire [7:0] cmd_w = (st_r == ST_CMD) ? rx : cmd_r;
    wire [3:0] cnt_inc = (cnt_r == LEN_MAX) ? cnt_r : cnt_r + 4'h1;

    // Header lengths; a read ends its header then sends one dummy byte
    wire arr_cmd = (cmd_w == OP_RD3) || (cmd_w == OP_RD4) || (cmd_w == OP_FREAD);
    wire rd_cmd = arr_cmd || (cmd_w == OP_PRD) || (cmd_w == OP_VRD) || (cmd_w == OP_PWDR);
    wire [3:0] rd_len = (cmd_w == OP_RD3) ? LEN_A3 :
                        (cmd_w == OP_PWDR) ? LEN_OP : LEN_A4;
    wire hdr_done = byte_ev && rd_cmd && (cnt_inc == rd_len)
                    && ((st_r == ST_CMD) || (st_r == ST_HDR));
    wire arr_blk = busy && arr_cmd;
    wire rd_go = hdr_done && !arr_blk;
    wire rd_blk = hdr_done && arr_blk;
    wire cmd_ign = (busy && (rx != OP_RDSR))
                   || (pwd_mode && ((rx == OP_PWDR) || (rx == OP_PWDP)));
    wire [31:0] addr_w = (cmd_w == OP_RD3) ? {8'h00, acc_r[15:0], rx} :
                         (cmd_w == OP_FREAD) ? {8'h00, acc_r[23:0]} :
                         (cmd_w == OP_PWDR) ? 32'h0000_0000 : {acc_r[23:0], rx};
    wire keep_cont = cont_r && (st_r == ST_RD);

    always_comb begin
        st_nxt = st_r;
        if (frame_end) begin
            st_nxt = keep_cont ? ST_HDR : ST_CMD;
        end else if (byte_ev) begin
            case (st_r)
                ST_CMD: begin
                    if (cmd_ign) begin
                        st_nxt = ST_IGN;
                    end else if (rd_go) begin
                        st_nxt = ST_RD;
                    end else begin
                        st_nxt = ST_HDR;
                    end
                end
                ST_HDR: begin
                    if (rd_blk) begin
                        st_nxt = ST_IGN;
                    end else if (rd_go) begin
                        st_nxt = ST_RD;
                    end
                end
                default: begin
                    st_nxt = st_r;
                end
            endcase
        end
    end

    // Commands act only at an aligned frame end with the exact length
    wire x_ok = frame_end && !mid_s2 && (st_r == ST_HDR);
    wire ex_lclr = x_ok && (cmd_r == OP_LCLR) && (cnt_r == LEN_OP);
    wire ex_srst = x_ok && (cmd_r == OP_SRST) && (cnt_r == LEN_OP);
    wire ex_clsr = x_ok && (cmd_r == OP_CLSR) && (cnt_r == LEN_OP);
    wire ex_pera = x_ok && (cmd_r == OP_PERA) && (cnt_r == LEN_OP);
    wire ex_ppgm = x_ok && (cmd_r == OP_PPGM) && (cnt_r == LEN_A4);
    wire ex_vwr = x_ok && (cmd_r == OP_VWR) && (cnt_r == LEN_VWR);
    wire ex_mode = x_ok && (cmd_r == OP_MODEP) && (cnt_r == LEN_MODE) && (mode_r == MODE_NONE);
    wire ex_unlk = x_ok && (cmd_r == OP_UNLK) && (cnt_r == LEN_PWD) && pwd_mode;
    wire ex_pwdp = x_ok && (cmd_r == OP_PWDP) && (cnt_r == LEN_PWD) && !pwd_mode;
    wire ex_pp = x_ok && (((cmd_r == OP_PP3) && (cnt_r == LEN_A3))
                          || ((cmd_r == OP_PP4) && (cnt_r == LEN_A4)));

    wire pwd_match = (acc_r == pwd_r);
    wire unlk_bad = ex_unlk && !pwd_match;
    wire unlk_good = ex_unlk && pwd_match;
    wire [SECT_W-1:0] sec = acc_r[SECT_LSB +: SECT_W];
    wire [SECT_W-1:0] vsec = acc_r[VSECT_LSB +: SECT_W];
    wire vdat = |acc_r[7:0];
    wire sec_unprot = pers_r[sec] & vol_r[sec];
    wire pp_ok = ex_pp && sec_unprot;
    wire pers_ok = (ex_ppgm || ex_pera) && lock_r;
    wire [1:0] mode_in = acc_r[MODE_LSB +: 2];
    wire mode_bad = ex_mode && (mode_in == MODE_BAD);
    wire perr_set = unlk_bad || mode_bad || (ex_pp && !sec_unprot)
                    || ((ex_ppgm || ex_pera) && !lock_r);
    wire op_start = pers_ok || ex_pwdp || (ex_mode && !mode_bad);

    genvar g;
    generate
        for (g = 0; g < SECT_N; g++) begin : g_sect
            assign pers_nxt[g] = (pers_ok && ex_pera) ? 1'b1 :
                                 (pers_ok && (sec == SECT_W'(g))) ? 1'b0 : pers_r[g];
            assign vol_nxt[g] = ex_srst ? 1'b1 :
                                (ex_vwr && (vsec == SECT_W'(g))) ? vdat : vol_r[g];
        end
    endgenerate

    // Nonvolatile state loads from outside cells during reset
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            pers_r <= i_nv_pers;
            pwd_r <= i_nv_pwd;
            mode_r <= i_nv_mode;
            lock_r <= (i_nv_mode != MODE_PWD);
            vol_r <= '1;
            p_err_r <= 1'b0;
            wip_cnt_r <= WIP_ZERO;
        end else begin
            pers_r <= pers_nxt;
            vol_r <= vol_nxt;
            if (ex_pwdp) begin
                pwd_r <= pwd_r & acc_r;
            end
            if (ex_mode && !mode_bad) begin
                mode_r <= mode_in;
            end
            if (ex_lclr) begin
                lock_r <= 1'b0;
            end else if (unlk_good) begin
                lock_r <= 1'b1;
            end
            // Set wins over the status clear
            p_err_r <= perr_set ? 1'b1 : (ex_clsr ? 1'b0 : p_err_r);
            // A wrong password holds busy for the retry gap
            if (unlk_bad) begin
                wip_cnt_r <= GAP_LD;
            end else if (op_start) begin
                wip_cnt_r <= OP_LD;
            end else if (busy) begin
                wip_cnt_r <= wip_cnt_r - WIP_ONE;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            st_r <= ST_CMD;
            cmd_r <= 8'h00;
            cnt_r <= LEN_NONE;
            acc_r <= '0;
            rd_ptr_r <= 32'h0000_0000;
            cont_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (frame_end) begin
                cnt_r <= keep_cont ? LEN_OP : LEN_NONE;
                acc_r <= '0;
                cont_r <= keep_cont;
            end else if (byte_ev) begin
                cnt_r <= cnt_inc;
                if (st_r == ST_CMD) begin
                    cmd_r <= rx;
                end else if (st_r == ST_HDR) begin
                    acc_r <= {acc_r[ACC_W-9:0], rx};
                end
                if (rd_go) begin
                    rd_ptr_r <= addr_w;
                    cont_r <= (cmd_w == OP_FREAD) && (rx[7:4] == CONT_NIB);
                end else if (st_r == ST_RD) begin
                    rd_ptr_r <= rd_ptr_r + 32'h0000_0001;
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            wr_req_r <= 1'b0;
            wr_addr_r <= 32'h0000_0000;
            unprot_r <= '0;
        end else begin
            wr_req_r <= pp_ok;
            if (pp_ok) begin
                wr_addr_r <= acc_r[31:0];
            end
            unprot_r <= pers_r & vol_r;
        end
    end

    always_comb begin
        stat_w = 8'h00;
        stat_w[STAT_WIP] = busy;
        stat_w[STAT_PERR] = p_err_r;
        stat_w[STAT_LOCK] = lock_r;
    end

    // Status is the idle answer so it needs no dummy byte
    wire [SECT_W-1:0] rsec = rd_ptr_r[SECT_LSB +: SECT_W];
    wire [7:0] pwd_byte = pwd_r[{~rd_ptr_r[2:0], 3'h0} +: 8];
    assign lk.tx = (st_r != ST_RD) ? stat_w :
                   (cmd_r == OP_PRD) ? {8{pers_r[rsec]}} :
                   (cmd_r == OP_VRD) ? {8{vol_r[rsec]}} :
                   (cmd_r == OP_PWDR) ? pwd_byte : i_rd_data;

    assign o_nv_pers = pers_r;
    assign o_nv_pwd = pwd_r;
    assign o_nv_mode = mode_r;
    assign o_sector_unprot = unprot_r;
    assign o_lock = lock_r;
    assign o_wip = busy;
    assign o_p_err = p_err_r;
    assign o_rd_addr = rd_ptr_r;
    assign o_wr_req = wr_req_r;
    assign o_wr_addr = wr_addr_r;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_bad_unlock;
        ex_unlk && (acc_r != pwd_r);
    endsequence

    sequence s_held_busy;
        (busy && p_err_r && $stable(lock_r)) [*8];
    endsequence

    a_lock_clear_zero: assert property (ex_lclr |=> !lock_r)
        else $error("lock clear did not clear lock");
    a_pers_frozen_lock: assert property (!lock_r |=> (pers_r == $past(pers_r)))
        else $error("persistent bits changed while locked");
    a_lock_after_reset: assert property ($rose(i_nrst) |-> (lock_r == (mode_r != MODE_PWD)))
        else $error("lock wrong after reset");
    a_bad_pwd_busy: assert property (s_bad_unlock |=> s_held_busy)
        else $error("bad password did not hold busy with error");
    a_good_pwd_free: assert property (unlk_good |=> (lock_r && !busy))
        else $error("good password did not unlock at once");
    a_pp_refused: assert property ((ex_pp && !sec_unprot) |=> (p_err_r && !o_wr_req))
        else $error("program of protected sector not refused");
    a_soft_reset_keeps: assert property (ex_srst |=> ($stable(lock_r) && (&vol_r)))
        else $error("soft reset wrong effect");
    a_pwd_hidden_ign: assert property ((byte_ev && (st_r == ST_CMD) && pwd_mode
                                       && (rx == OP_PWDR)) |=> (st_r == ST_IGN))
        else $error("password read not ignored");
    a_pwd_clear_only: assert property (ex_pwdp |=> (pwd_r == ($past(pwd_r) & $past(acc_r))))
        else $error("password program set a bit");
    a_busy_rd_ign: assert property ((byte_ev && busy && (st_r == ST_CMD)
                                    && (rx == OP_RD3)) |=> (st_r == ST_IGN))
        else $error("array read accepted while busy");
    a_misaligned_end: assert property ((frame_end && mid_s2) |=> ($stable(lock_r)
                                       && $stable(pers_r) && $stable(vol_r)))
        else $error("misaligned frame executed");
    a_vol_write_val: assert property (ex_vwr |=> (vol_r[$past(vsec)] == $past(vdat)))
        else $error("volatile write wrong value");
endmodule : sector_protect

// [bench/spi_host_model.sv]
/*
 Host serial controller model: mode 0 frames on its own 160 ns clock.
 Assumes the bench calls xfer from one process and waits for its return.
*/
module spi_host_model (
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b1;
    end
    // Clock stands still between frames; odd offsets keep it unrelated
    task automatic xfer(input int nb, input logic [7:0] tx [12],
                        output logic [7:0] rx [12]);
        o_cs_n = 1'b0;
        #37;
        for (int k = 0; k < nb; k++) begin
            o_si = tx[k/8][7-k%8];
            #80 o_sck = 1'b1;
            rx[k/8][7-k%8] = i_so;
            #80 o_sck = 1'b0;
        end
        #37 o_cs_n = 1'b1;
        // Released line shows no stale value
        o_si = ~o_si;
        #300;
    endtask : xfer
endmodule : spi_host_model

// [bench/sector_protect_bench.sv]
/*
 Self-checking bench of the sector protection core with a host model.
 Assumes the core reads nonvolatile inputs during reset.
*/
module sector_protect_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sp_pkg::*;
    localparam logic [63:0] PWD = 64'h0123_4567_89AB_CDEF;
    localparam logic [255:0] PERS = ~256'hF0;
    typedef struct {logic [1:0] mode; logic lock;} row_t;
    row_t rows [3] = '{'{2'h1, 1'b0}, '{2'h2, 1'b1}, '{2'h3, 1'b1}};
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] nv_mode = 2'h3;
    logic [63:0] nv_pwd = PWD;
    logic sck, cs_n, si, so, so_oe, lock, write_in_progress_flag, p_err, wr_req;
    logic [1:0] nv_mode_now;
    logic [255:0] unprot, nv_pers;
    logic [63:0] pwd_now;
    logic [31:0] rd_addr, wr_addr;
    logic [7:0] rd_data;
    logic [7:0] tx [12];
    logic [7:0] rx [12];
    int failures = 0;
    int total_checks = 0;
    int wr_cnt = 0;

    always #20 mclk = ~mclk;
    // Array answers its address at once
    assign rd_data = rd_addr[7:0] ^ 8'h5A;
    always @(posedge mclk) if (wr_req === 1'b1) wr_cnt++;

    spi_host_model host_u (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so));
    sector_protect dut_u (.i_mclk(mclk), .i_nrst(nrst), .i_sck(sck), .i_cs_n(cs_n),
        .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_nv_pers(PERS), .i_nv_pwd(nv_pwd),
        .i_nv_mode(nv_mode), .o_nv_pers(nv_pers), .o_nv_pwd(pwd_now),
        .o_nv_mode(nv_mode_now),
        .o_sector_unprot(unprot), .o_lock(lock), .o_wip(write_in_progress_flag), .o_p_err(p_err),
        .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_wr_req(wr_req),
        .o_wr_addr(wr_addr));

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rst(input logic [1:0] m);
        nv_mode <= m;
        nrst <= 1'b0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask : rst
    task automatic hdr(input logic [7:0] op, input logic [63:0] v, input int n);
        tx[0] = op;
        for (int i = 0; i < n; i++) tx[1+i] = v[8*(n-1-i) +: 8];
    endtask : hdr
    task automatic cmd(input int nb);
        host_u.xfer(nb, tx, rx);
        repeat (8) @(posedge mclk);
    endtask : cmd
    task automatic idle;
        for (int i = 0; i < 3000 && write_in_progress_flag !== 1'b0; i++) @(posedge mclk);
        chk("wip idle", 64'h0, write_in_progress_flag);
    endtask : idle
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    initial begin
        repeat (30000) @(posedge mclk);
        failures++;
        finish_test();
    end

    initial begin
        @(posedge mclk);
        foreach (rows[r]) begin
            rst(rows[r].mode);
            chk("lock reset", rows[r].lock, lock);
            chk("unprot reset", PERS[63:0], unprot[63:0]);
            tx[0] = OP_RDSR;
            cmd(16);
            chk("status", {rows[r].lock, 7'h00}, rx[1]);
        end
        $display("reset rows done");
        chk("oe idle", 64'h0, so_oe);
        hdr(OP_VWR, 32'h0018_0000, 4);
        tx[5] = 8'h00;
        cmd(48);
        chk("vol protect", 64'h0, unprot[3]);
        tx[5] = 8'h01;
        cmd(48);
        chk("vol unprotect", 64'h1, unprot[3]);
        hdr(OP_PPGM, 32'h0008_0000, 4);
        cmd(40);
        idle();
        chk("pers prog", 64'h0, nv_pers[1]);
        chk("pers unprot", 64'h0, unprot[1]);
        // Page program frame is opcode and address only
        hdr(OP_PP3, 32'h10, 3);
        cmd(32);
        chk("wr count", 64'h1, wr_cnt);
        chk("wr addr", 64'h10, wr_addr);
        hdr(OP_PP3, 32'h0008_0000, 3);
        cmd(32);
        chk("wr refused", 64'h1, wr_cnt);
        chk("perr pp", 64'h1, p_err);
        tx[0] = OP_CLSR;
        cmd(8);
        $display("sector bits done");
        tx[0] = OP_LCLR;
        cmd(11);
        chk("lock misaligned", 64'h1, lock);
        cmd(8);
        chk("lock clear", 64'h0, lock);
        tx[0] = OP_PERA;
        cmd(8);
        idle();
        chk("perr locked", 64'h1, p_err);
        chk("pers kept", 64'h0, nv_pers[1]);
        hdr(OP_VWR, 32'h0, 4);
        tx[5] = 8'h00;
        cmd(48);
        chk("vol locked", 64'h0, unprot[0]);
        tx[0] = OP_SRST;
        cmd(8);
        chk("soft vol", 64'h1, unprot[0]);
        chk("soft lock", 64'h0, lock);
        $display("lock tests done");
        hdr(OP_FREAD, 32'h123, 3);
        tx[4] = 8'hA0;
        cmd(64);
        chk("read 0", 64'h79, rx[6]);
        chk("read 1", 64'h7E, rx[7]);
        // No opcode: the address bytes lead the frame
        hdr(8'h00, 32'h0200, 2);
        tx[3] = 8'h00;
        cmd(56);
        chk("cont read", 64'h5A, rx[5]);
        hdr(OP_RD3, 32'h45, 3);
        cmd(48);
        chk("read 3", 64'h1F, rx[5]);
        hdr(OP_PRD, 32'h0008_0000, 4);
        cmd(56);
        chk("pers read", 64'h00, rx[6]);
        tx[0] = OP_VRD;
        cmd(56);
        chk("vol read", 64'hFF, rx[6]);
        $display("read tests done");
        rst(2'h3);
        hdr(OP_PWDP, 64'hFFFF_0000_FFFF_FFFF, 8);
        cmd(72);
        idle();
        chk("pwd and", PWD & 64'hFFFF_0000_FFFF_FFFF, pwd_now);
        tx[0] = OP_MODEP;
        tx[1] = 8'h00;
        cmd(16);
        chk("mode bad", 64'h1, p_err);
        tx[1] = 8'h04;
        cmd(16);
        idle();
        chk("mode set", 64'h2, nv_mode_now);
        rst(2'h1);
        hdr(OP_UNLK, ~PWD, 8);
        cmd(72);
        chk("perr bad", 64'h1, p_err);
        chk("wip bad", 64'h1, write_in_progress_flag);
        chk("lock bad", 64'h0, lock);
        // Only status is served during the gap
        tx[0] = OP_RDSR;
        cmd(16);
        chk("status busy", 64'h41, rx[1]);
        hdr(OP_RD3, 32'h0, 3);
        cmd(48);
        chk("busy read", 64'h41, rx[5]);
        repeat (2000) @(posedge mclk);
        chk("wip gap", 64'h1, write_in_progress_flag);
        idle();
        tx[0] = OP_CLSR;
        cmd(8);
        hdr(OP_UNLK, PWD, 8);
        cmd(72);
        chk("lock good", 64'h1, lock);
        chk("wip good", 64'h0, write_in_progress_flag);
        hdr(OP_PWDP, 64'h0, 8);
        cmd(72);
        idle();
        chk("pwd guarded", PWD, pwd_now);
        $display("password tests done");
        finish_test();
    end
endmodule : sector_protect_bench
